// ### hw/pea_annunciator.sv
// beep and blink sequencer with progress code latch
`timescale 1ns/10ps
module pea_annunciator #(
  parameter logic [23:0] QUARTER_CYC = 24'(pea_pkg::QUARTER_CYC),
  parameter logic [15:0] HALF_MID = 16'(pea_pkg::HALF_MID_CYC),
  parameter logic [15:0] HALF_HIGH = 16'(pea_pkg::HALF_HIGH_CYC),
  parameter logic [15:0] HALF_LOW = 16'(pea_pkg::HALF_LOW_CYC)
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic promptReq,
  input wire logic fwUpdStart,
  input wire logic fwUpdDone,
  input wire logic videoErr,
  input wire logic memErr,
  input wire logic thermTrip,
  input wire logic ioWrStrobe,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioData,
  output logic speakerOut,
  output logic ledOut_q,
  output logic bootContinue_q,
  output logic shutdownReq_q,
  output logic [7:0] postCode_q,
  output logic postSleepEnter_q,
  output logic postResume_q,
  output logic postFatal_q
);

  // ****************************************
  // sequencer state
  // ****************************************
  pea_pkg::pea_state_t state_q;
  pea_pkg::pea_state_t reqState;
  logic [23:0] tickCnt_q;
  logic quarterTick;
  logic [5:0] stepCnt_q;
  logic [5:0] frameLen;
  logic lastStep;
  logic [1:0] repCnt_q;
  logic startNew;
  logic toneEn;
  logic ledNext;
  logic [15:0] halfSel;
  logic portWr;
  logic [7:0] codeNext;

  // highest pending event wins; thermal outranks memory, video, update, prompt
  always_comb begin
    reqState = pea_pkg::PEA_IDLE;
    if (thermTrip) begin
      reqState = pea_pkg::PEA_THERMAL;
    end else if (memErr) begin
      reqState = pea_pkg::PEA_MEMORY;
    end else if (videoErr) begin
      reqState = pea_pkg::PEA_VIDEO;
    end else if (fwUpdStart) begin
      reqState = pea_pkg::PEA_FWUPD;
    end else if (promptReq) begin
      reqState = pea_pkg::PEA_PROMPT;
    end
  end

  // a request only preempts a lower pattern; halt is final until reset
  assign startNew = (reqState != pea_pkg::PEA_IDLE) && (reqState > state_q)
                    && (state_q != pea_pkg::PEA_HALT);

  // frame length of the running pattern in quarter steps
  always_comb begin
    case (state_q)
      pea_pkg::PEA_PROMPT: frameLen = pea_pkg::PROMPT_STEPS;
      pea_pkg::PEA_FWUPD: frameLen = pea_pkg::FW_STEPS;
      pea_pkg::PEA_VIDEO: frameLen = 6'(2 * pea_pkg::VIDEO_BEEPS * pea_pkg::BEEP_STEPS
                                       + pea_pkg::PAUSE_STEPS);
      pea_pkg::PEA_MEMORY: frameLen = 6'(2 * pea_pkg::MEM_BEEPS * pea_pkg::BEEP_STEPS
                                        + pea_pkg::PAUSE_STEPS);
      pea_pkg::PEA_THERMAL: frameLen = 6'(pea_pkg::THERM_BEEPS * pea_pkg::BEEP_STEPS);
      default: frameLen = 6'h01;
    endcase
  end

  assign quarterTick = (tickCnt_q == QUARTER_CYC - 24'h000001);
  assign lastStep = quarterTick && (stepCnt_q == frameLen - 6'h01);

  // ****************************************
  // time base
  // ****************************************

  // quarter second divider, realigned at each new pattern
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tickCnt_q <= '0;
    end else if (startNew || quarterTick || state_q == pea_pkg::PEA_IDLE) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + 24'h000001;
    end
  end

  // step counter within a frame, wraps on repeating patterns
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stepCnt_q <= '0;
    end else if (startNew || lastStep) begin
      stepCnt_q <= '0;
    end else if (quarterTick) begin
      stepCnt_q <= stepCnt_q + 6'h01;
    end
  end

  // ****************************************
  // pattern control
  // ****************************************

  // state transitions at pattern start, frame end and update done
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= pea_pkg::PEA_IDLE;
    end else if (startNew) begin
      state_q <= reqState;
    end else begin
      case (state_q)
        pea_pkg::PEA_PROMPT: begin
          if (lastStep) begin
            state_q <= pea_pkg::PEA_IDLE;
          end
        end
        pea_pkg::PEA_FWUPD: begin
          if (fwUpdDone) begin
            state_q <= pea_pkg::PEA_IDLE;
          end
        end
        pea_pkg::PEA_THERMAL: begin
          if (lastStep) begin
            state_q <= pea_pkg::PEA_HALT;
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // video frame count; the tone stops after two frames, the LED goes on
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      repCnt_q <= '0;
    end else if (startNew) begin
      repCnt_q <= '0;
    end else if (state_q == pea_pkg::PEA_VIDEO && lastStep
                 && repCnt_q != pea_pkg::VIDEO_REPEATS) begin
      repCnt_q <= repCnt_q + 2'h1;
    end
  end

  // one-cycle pulses for boot resume and system shutdown
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bootContinue_q <= 1'b0;
      shutdownReq_q <= 1'b0;
    end else begin
      bootContinue_q <= !startNew && state_q == pea_pkg::PEA_VIDEO && lastStep
                        && repCnt_q == pea_pkg::VIDEO_REPEATS - 2'h1;
      shutdownReq_q <= !startNew && state_q == pea_pkg::PEA_THERMAL && lastStep;
    end
  end

  // tone gating, frequency and LED level per pattern step
  always_comb begin
    toneEn = 1'b0;
    ledNext = 1'b0;
    halfSel = HALF_MID;
    case (state_q)
      pea_pkg::PEA_PROMPT: begin
        toneEn = 1'b1;
      end
      pea_pkg::PEA_FWUPD: begin
        ledNext = stepCnt_q[1];
      end
      pea_pkg::PEA_VIDEO: begin
        ledNext = !stepCnt_q[2]
                  && stepCnt_q < 6'(2 * pea_pkg::VIDEO_BEEPS * pea_pkg::BEEP_STEPS);
        toneEn = ledNext && repCnt_q != pea_pkg::VIDEO_REPEATS;
      end
      pea_pkg::PEA_MEMORY: begin
        ledNext = !stepCnt_q[2]
                  && stepCnt_q < 6'(2 * pea_pkg::MEM_BEEPS * pea_pkg::BEEP_STEPS);
        toneEn = ledNext;
      end
      pea_pkg::PEA_THERMAL: begin
        toneEn = 1'b1;
        halfSel = stepCnt_q[2] ? HALF_LOW : HALF_HIGH;
        ledNext = !stepCnt_q[0];
      end
      default: begin
        toneEn = 1'b0;
      end
    endcase
  end

  // LED output registered; bit 2 of the step is the 1 s beep parity
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ledOut_q <= 1'b0;
    end else begin
      ledOut_q <= ledNext;
    end
  end

  pea_tone_gen #(
    .WIDTH(16)
  ) toneGen (
    .clock(clock),
    .rstn(rstn),
    .enable(toneEn),
    .halfPeriod(halfSel),
    .toneOut_q(speakerOut)
  );

  // ****************************************
  // progress code latch
  // ****************************************
  assign portWr = ioWrStrobe && ioAddr == pea_pkg::PORT80_ADDR;
  assign codeNext = portWr ? ioData : postCode_q;

  // latch and decode together so flags never lag the code
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      postCode_q <= pea_pkg::CODE_RESET;
      postSleepEnter_q <= 1'b0;
      postResume_q <= 1'b0;
      postFatal_q <= 1'b0;
    end else begin
      postCode_q <= codeNext;
      postSleepEnter_q <= codeNext <= pea_pkg::CODE_SLEEP_MAX;
      postResume_q <= codeNext[3:0] == 4'h0 && codeNext[7:4] >= pea_pkg::RESUME_HI_MIN
                      && codeNext[7:4] <= pea_pkg::RESUME_HI_MAX;
      postFatal_q <= codeNext == pea_pkg::CODE_FATAL;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  prompt_no_led_a: assert property (
    state_q == pea_pkg::PEA_PROMPT |=> !ledOut_q)
    else $error("led lit during prompt tone");
  fw_silent_a: assert property (
    state_q == pea_pkg::PEA_FWUPD |-> !toneEn && halfSel == HALF_MID)
    else $error("speaker active during update");
  fw_first_off_a: assert property (
    startNew && reqState == pea_pkg::PEA_FWUPD |=> ##1 !ledOut_q)
    else $error("led not off at update start");
  video_once_a: assert property (
    state_q == pea_pkg::PEA_VIDEO && repCnt_q == pea_pkg::VIDEO_REPEATS |-> !toneEn)
    else $error("video tone past second frame");
  video_freq_a: assert property (
    toneEn && state_q != pea_pkg::PEA_THERMAL |-> halfSel == HALF_MID)
    else $error("wrong tone frequency");
  mem_pair_a: assert property (
    state_q == pea_pkg::PEA_MEMORY |=> ledOut_q == $past(toneEn))
    else $error("memory tone and led disagree");
  video_led_a: assert property (
    state_q == pea_pkg::PEA_VIDEO && stepCnt_q >= 6'h10 |=> !ledOut_q)
    else $error("video led lit in pause");
  therm_alt_a: assert property (
    state_q == pea_pkg::PEA_THERMAL |-> toneEn
      && halfSel == (stepCnt_q[2] ? HALF_LOW : HALF_HIGH))
    else $error("thermal tone not alternating");
  therm_blink_a: assert property (
    state_q == pea_pkg::PEA_THERMAL |=> ledOut_q == !$past(stepCnt_q[0]))
    else $error("thermal blink wrong");
  therm_halt_a: assert property (
    state_q == pea_pkg::PEA_THERMAL && lastStep |=> shutdownReq_q
      && state_q == pea_pkg::PEA_HALT ##1 !shutdownReq_q && !toneEn)
    else $error("no shutdown after eighth tone");
  code_cap_a: assert property (
    portWr |=> postCode_q == $past(ioData))
    else $error("progress code not captured");
  code_hold_a: assert property (
    !portWr |=> $stable(postCode_q) && $stable(postFatal_q))
    else $error("progress code changed without write");
  code_fatal_a: assert property (
    portWr && ioData == pea_pkg::CODE_FATAL |=> postFatal_q && !postResume_q)
    else $error("fatal code not flagged");

  video_done_c: cover property (bootContinue_q);
  shutdown_c: cover property (shutdownReq_q);
  fw_done_c: cover property (state_q == pea_pkg::PEA_FWUPD && fwUpdDone);
  mem_wrap_c: cover property (state_q == pea_pkg::PEA_MEMORY && lastStep);

endmodule

// ### inc/pea_pkg.sv
// shared constants and types of the post error annunciator
package pea_pkg;

  // ****************************************
  // clock and time base
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int QUARTER_MS = 250;
  localparam int QUARTER_CYC = CLK_HZ / 1000 * QUARTER_MS;

  // ****************************************
  // tone frequencies and half periods
  // ****************************************
  localparam int TONE_MID_HZ = 932;
  localparam int TONE_HIGH_HZ = 2000;
  localparam int TONE_LOW_HZ = 1500;
  localparam int HALF_MID_CYC = CLK_HZ / (2 * TONE_MID_HZ);
  localparam int HALF_HIGH_CYC = CLK_HZ / (2 * TONE_HIGH_HZ);
  localparam int HALF_LOW_CYC = CLK_HZ / (2 * TONE_LOW_HZ);

  // ****************************************
  // pattern lengths in quarter-second steps, beep counts and video frame count
  // ****************************************
  localparam logic [5:0] PROMPT_STEPS = 6'h02;
  localparam logic [5:0] FW_STEPS = 6'h04;
  localparam logic [5:0] BEEP_STEPS = 6'h04;
  localparam logic [5:0] PAUSE_STEPS = 6'h0a;
  localparam logic [5:0] VIDEO_BEEPS = 6'h02;
  localparam logic [5:0] MEM_BEEPS = 6'h03;
  localparam logic [5:0] THERM_BEEPS = 6'h08;
  localparam logic [1:0] VIDEO_REPEATS = 2'h2;

  // ****************************************
  // progress code port
  // ****************************************
  localparam logic [15:0] PORT80_ADDR = 16'h0080;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [7:0] CODE_FATAL = 8'h5f;
  localparam logic [7:0] CODE_SLEEP_MAX = 8'h05;
  localparam logic [3:0] RESUME_HI_MIN = 4'h1;
  localparam logic [3:0] RESUME_HI_MAX = 4'h5;

  // ****************************************
  // sequencer states, ordered by priority
  // ****************************************
  typedef enum logic [2:0] {
    PEA_IDLE,
    PEA_PROMPT,
    PEA_FWUPD,
    PEA_VIDEO,
    PEA_MEMORY,
    PEA_THERMAL,
    PEA_HALT
  } pea_state_t;

endpackage

// ### hw/pea_tone_gen.sv
// square wave tone generator with selectable half period
`timescale 1ns/10ps
module pea_tone_gen #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic enable,
  input wire logic [WIDTH-1:0] halfPeriod,
  output logic toneOut_q
);

  logic [WIDTH-1:0] halfCnt_q;

  // half period counter, restarts whenever the tone is gated off
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      halfCnt_q <= '0;
    end else if (!enable || halfCnt_q >= halfPeriod - WIDTH'(1)) begin
      halfCnt_q <= '0;
    end else begin
      halfCnt_q <= halfCnt_q + WIDTH'(1);
    end
  end

  // output flips each half period; low when silent so the speaker idles off
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      toneOut_q <= 1'b0;
    end else if (!enable) begin
      toneOut_q <= 1'b0;
    end else if (halfCnt_q >= halfPeriod - WIDTH'(1)) begin
      toneOut_q <= ~toneOut_q;
    end
  end

endmodule

// ### dv/pea_board_model.sv
// board side model: speaker, shutdown logic and progress code display card
`timescale 1ns/10ps
module pea_board_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic speakerOut,
  input wire logic bootContinue_q,
  input wire logic shutdownReq_q,
  input wire logic ioWrStrobe,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioData,
  output int toneEdges,
  output int bootPulses,
  output int shutPulses,
  output logic [7:0] shownCode,
  output logic shownFatal
);
  logic spkPrev;

  // ****************************************
  // speaker and power sequencing
  // ****************************************
  // counts every speaker transition; a stopped tone must give none
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      spkPrev <= 1'b0;
      toneEdges <= 0;
      bootPulses <= 0;
      shutPulses <= 0;
    end else begin
      spkPrev <= speakerOut;
      if (speakerOut != spkPrev) toneEdges <= toneEdges + 1;
      if (bootContinue_q) bootPulses <= bootPulses + 1;
      if (shutdownReq_q) shutPulses <= shutPulses + 1;
    end
  end

  // ****************************************
  // display card
  // ****************************************
  // the card snoops the bus itself, so it never sees refused addresses
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shownCode <= 8'h00;
      shownFatal <= 1'b0;
    end else if (ioWrStrobe && ioAddr == 16'h0080) begin
      shownCode <= ioData;
      shownFatal <= (ioData == 8'h5f);
    end
  end
endmodule

// ### dv/tb.sv
// self-checking bench for the post error annunciator
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] code;
    logic [2:0] flags;
  } pea_row_t;

  logic clock, rstn, ioWrStrobe, speakerOut, ledOut_q, bootContinue_q, shutdownReq_q;
  logic postSleepEnter_q, postResume_q, postFatal_q, shownFatal;
  logic [5:0] ev;
  logic [15:0] ioAddr;
  logic [7:0] ioData, postCode_q, shownCode;
  int toneEdges, bootPulses, shutPulses, num_errors, n_tests, cycles;
  int qe [64];
  // flags are sleep, resume, fatal; the 0081h row must leave the latch alone
  pea_row_t rows [10] = '{'{16'h0080, 8'h00, 8'h00, 3'h4}, '{16'h0080, 8'h05, 8'h05, 3'h4},
    '{16'h0080, 8'h06, 8'h06, 3'h0}, '{16'h0080, 8'h10, 8'h10, 3'h2},
    '{16'h0080, 8'h50, 8'h50, 3'h2}, '{16'h0080, 8'h55, 8'h55, 3'h0},
    '{16'h0080, 8'h5f, 8'h5f, 3'h1}, '{16'h0081, 8'haa, 8'h5f, 3'h1},
    '{16'h0080, 8'h60, 8'h60, 3'h0}, '{16'h0080, 8'ha0, 8'ha0, 3'h0}};

  // ****************************************
  // design, board model, clock
  // ****************************************
  // short quarter and half periods keep every pattern to a few hundred cycles
  pea_annunciator #(.QUARTER_CYC(24'h000004), .HALF_MID(16'h0003), .HALF_HIGH(16'h0002),
    .HALF_LOW(16'h0003)) dut (.clock(clock), .rstn(rstn), .promptReq(ev[0]),
    .fwUpdStart(ev[1]), .fwUpdDone(ev[2]), .videoErr(ev[3]), .memErr(ev[4]),
    .thermTrip(ev[5]), .ioWrStrobe(ioWrStrobe), .ioAddr(ioAddr), .ioData(ioData),
    .speakerOut(speakerOut), .ledOut_q(ledOut_q), .bootContinue_q(bootContinue_q),
    .shutdownReq_q(shutdownReq_q), .postCode_q(postCode_q),
    .postSleepEnter_q(postSleepEnter_q), .postResume_q(postResume_q),
    .postFatal_q(postFatal_q));

  pea_board_model board (.clock(clock), .rstn(rstn), .speakerOut(speakerOut),
    .bootContinue_q(bootContinue_q), .shutdownReq_q(shutdownReq_q),
    .ioWrStrobe(ioWrStrobe), .ioAddr(ioAddr), .ioData(ioData), .toneEdges(toneEdges),
    .bootPulses(bootPulses), .shutPulses(shutPulses), .shownCode(shownCode),
    .shownFatal(shownFatal));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // hang guard, far above the roughly eight hundred cycles of the run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // modes: 1 prompt, 2 update, 3 video, 4 memory, 5 thermal, else silent and dark
  function automatic logic expLed(input int m, input int q);
    case (m)
      2: return (q % 4) >= 2;
      // beep parity restarts with every frame; frames are not a multiple of 8 quarters
      3: return (q % 26) < 12 && ((q % 26) % 8) < 4;
      4: return (q % 34) < 20 && ((q % 34) % 8) < 4;
      5: return q < 32 && (q % 2) == 0;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic expTone(input int m, input int q);
    case (m)
      1: return q < 2;
      3: return q < 52 && expLed(3, q);
      4: return expLed(4, q);
      5: return q < 32;
      default: return 1'b0;
    endcase
  endfunction

  task automatic pulse(input int b);
    ev[b] = 1'b1;
    @(negedge clock);
    ev = 6'h00;
  endtask

  // samples the led at the end of each quarter; tone edges judged away from on/off boundaries
  task automatic runQ(input int m, input int nq);
    int e0;
    for (int q = 0; q < nq; q++) begin
      e0 = toneEdges;
      repeat (4) @(negedge clock);
      qe[q % 64] = toneEdges - e0;
      chk(8'(ledOut_q), 8'(expLed(m, q)), "led pattern");
      if (q > 0 && expTone(m, q) && expTone(m, q - 1)) chk(8'(qe[q % 64] > 0), 8'h01, "no tone");
      if (q > 0 && !expTone(m, q) && !expTone(m, q - 1)) chk(8'(qe[q % 64]), 8'h00, "tone");
    end
  endtask

  task automatic doReset;
    rstn = 1'b0;
    repeat (8) @(negedge clock);
    chk(postCode_q, 8'h00, "latch not cleared");
    chk({ledOut_q, speakerOut, bootContinue_q, shutdownReq_q, postFatal_q}, 8'h00, "reset");
    rstn = 1'b1;
    @(negedge clock);
    chk({postSleepEnter_q, postResume_q}, 8'h02, "code 00h decode");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    ev = 6'h00;
    ioWrStrobe = 1'b0;
    ioAddr = 16'h0000;
    ioData = 8'h00;
    doReset();
    // back-to-back writes: the strobe stays high across all rows
    foreach (rows[i]) begin
      ioWrStrobe = 1'b1;
      ioAddr = rows[i].addr;
      ioData = rows[i].data;
      @(negedge clock);
      chk(postCode_q, rows[i].code, "latched code");
      chk({postSleepEnter_q, postResume_q, postFatal_q}, rows[i].flags, "code class");
      chk(shownCode, rows[i].code, "card code");
      chk(8'(shownFatal), 8'(rows[i].flags[0]), "card fatal");
    end
    ioWrStrobe = 1'b0;
    pulse(4);
    runQ(4, 70);
    chk(postCode_q, 8'ha0, "latch moved during error");
    pulse(5);
    runQ(5, 40);
    chk(8'(qe[1] + qe[2] + qe[3] > qe[5] + qe[6] + qe[7]), 8'h01, "high beep not higher");
    chk(8'(shutPulses), 8'h01, "shutdown pulse");
    pulse(4);
    runQ(6, 4);
    doReset();
    pulse(3);
    runQ(3, 60);
    chk(8'(bootPulses), 8'h01, "boot continue");
    doReset();
    pulse(1);
    runQ(2, 8);
    pulse(2);
    @(negedge clock);
    @(negedge clock);
    chk(8'(ledOut_q), 8'h00, "led after update");
    runQ(0, 4);
    pulse(0);
    runQ(1, 6);
    tally_and_finish();
  end
endmodule
